/* common/timer_pkg.sv */
// Constants, register offsets and mode codes for the dual timer/counter block.
// Assumes a plain register port with one-cycle read latency; one clock domain.
package timer_pkg;
  localparam logic [3:0] ADDR_MODE = 4'h0;
  localparam logic [3:0] ADDR_CTRL = 4'h1;
  localparam logic [3:0] ADDR_CTRL_B = 4'h2;
  localparam logic [3:0] ADDR_CLKCTL = 4'h3;
  localparam logic [3:0] ADDR_T0_LOW = 4'h4;
  localparam logic [3:0] ADDR_T0_HIGH = 4'h5;
  localparam logic [3:0] ADDR_T1_LOW = 4'h6;
  localparam logic [3:0] ADDR_T1_HIGH = 4'h7;
  localparam logic [3:0] ADDR_T0_RLOW = 4'h8;
  localparam logic [3:0] ADDR_T0_RHIGH = 4'h9;
  localparam logic [3:0] ADDR_T1_RLOW = 4'hA;
  localparam logic [3:0] ADDR_T1_RHIGH = 4'hB;
  localparam logic [3:0] ADDR_PRESCALE = 4'hC;
  // Mode register fields, per timer nibble base 0 or 4
  localparam int MODE_M0_BIT = 0;
  localparam int MODE_CT_BIT = 2;
  localparam int MODE_GATE_BIT = 3;
  // Control register fields
  localparam int CTRL_TR0_BIT = 4;
  localparam int CTRL_TF0_BIT = 5;
  localparam int CTRL_TR1_BIT = 6;
  localparam int CTRL_TF1_BIT = 7;
  // Control B fields
  localparam int CTLB_PWM1_BIT = 7;
  localparam int CTLB_PWM0_BIT = 6;
  localparam int CTLB_PSC1_LSB = 3;
  localparam int CTLB_PSC0_LSB = 0;
  // Clock control fields: bit 0 compat mode, bits 1/2 double-rate t0/t1
  localparam int CLK_COMPAT_BIT = 0;
  localparam int CLK_X2_T0_BIT = 1;
  localparam int CLK_X2_T1_BIT = 2;
  localparam logic [7:0] CTRL_B_RESET = 8'h24;
  localparam logic [7:0] RELOAD_RESET = 8'h00;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] BYTE_ONES = 8'hFF;
  localparam logic [3:0] PRESCALE_RESET = 4'h0;
  typedef enum logic [1:0] {
    MODE_VAR = 2'b00,
    MODE_R16 = 2'b01,
    MODE_R8 = 2'b10,
    MODE_SPLIT = 2'b11
  } tmode_t;
endpackage

/* design/dual_timer_counter_pwm.sv */
// Dual timer/counter with PWM outputs and a register port.
// Assumes gate pins are asynchronous; counter-mode pin sampling is not built.
`timescale 1ns/10ps
module dual_timer_counter_pwm
  import timer_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic t0_gate_pin,
  input wire logic t1_gate_pin,
  output logic t0_ext_pin_o,
  output logic t0_ext_pin_oe,
  output logic t1_ext_pin_o,
  output logic t1_ext_pin_oe,
  output logic t0_overflow_flag,
  output logic t1_overflow_flag,
  output logic t1_baud_tick
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0] timer_mode_reg_r;
  logic [7:0] timer_control_reg_r;
  logic [7:0] timer_control_b_r;
  logic [7:0] clock_control_zero_r;
  logic [3:0] shared_prescale_value_r;
  logic [7:0] cnt_low_r [2];
  logic [7:0] cnt_high_r [2];
  logic [7:0] reload_low_r [2];
  logic [7:0] reload_high_r [2];
  logic [7:0] compare_latch_r [2];
  logic [3:0] presc_cnt_r [2];
  logic [2:0] g0_sync_r;
  logic [2:0] g1_sync_r;
  logic t0_gate_select_r;
  logic t1_gate_select_r;
  logic pwm_out_r [2];

  // Mode field decode, used for both timers
  function automatic tmode_t mode_of(input logic [7:0] m, input int t);
    mode_of = tmode_t'(m[t*4+MODE_M0_BIT +: 2]);
  endfunction

  // Mode 0 low-byte mask: prescale field plus one active bits
  function automatic logic [7:0] low_mask(input logic [2:0] psc);
    low_mask = 8'((9'h002 << psc) - 9'h001);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Gate pin synchronisers: three stages, change counts once stages 2 and 3 agree
  always_ff @(posedge clk) begin
    if (reset) begin
      g0_sync_r <= 3'h0;
      g1_sync_r <= 3'h0;
      t0_gate_select_r <= 1'b0;
      t1_gate_select_r <= 1'b0;
    end else begin
      g0_sync_r <= {g0_sync_r[1:0], t0_gate_pin};
      g1_sync_r <= {g1_sync_r[1:0], t1_gate_pin};
      if (g0_sync_r[2] == g0_sync_r[1]) begin
        t0_gate_select_r <= g0_sync_r[2];
      end
      if (g1_sync_r[2] == g1_sync_r[1]) begin
        t1_gate_select_r <= g1_sync_r[2];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-timer enables and prescaler ticks
  logic run [2];
  logic tick [2];
  logic psc_used [2];
  logic gated [2];
  // Compat mode with double rate halves the tick rate by skipping every other wrap
  logic dbl_rate [2];
  logic dbl_ph_r [2];
  tmode_t tm [2];
  logic pwm_en [2];
  logic split0;

  assign split0 = (mode_of(timer_mode_reg_r, 0) == MODE_SPLIT);
  assign gated[0] = ~timer_mode_reg_r[MODE_GATE_BIT] | t0_gate_select_r;
  assign gated[1] = ~timer_mode_reg_r[4+MODE_GATE_BIT] | t1_gate_select_r;
  assign pwm_en[0] = timer_control_b_r[CTLB_PWM0_BIT];
  assign pwm_en[1] = timer_control_b_r[CTLB_PWM1_BIT];

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_en
      assign tm[gi] = mode_of(timer_mode_reg_r, gi);
      // Compat mode always prescales; fast mode only with double-rate set
      assign psc_used[gi] = clock_control_zero_r[CLK_COMPAT_BIT] |
                            clock_control_zero_r[CLK_X2_T0_BIT + gi];
      assign dbl_rate[gi] = clock_control_zero_r[CLK_COMPAT_BIT] &
                            clock_control_zero_r[CLK_X2_T0_BIT + gi];
      assign tick[gi] = ~psc_used[gi] | ((presc_cnt_r[gi] == shared_prescale_value_r) &
                        (~dbl_rate[gi] | dbl_ph_r[gi]));
    end
  endgenerate

  // Timer 0 runs on its own bit; gate still halts PWM too
  assign run[0] = timer_control_reg_r[CTRL_TR0_BIT] & gated[0] & tick[0];
  // Timer 1 holds in its own mode 3
  assign run[1] = timer_control_reg_r[CTRL_TR1_BIT] & gated[1] & tick[1] &
                  (tm[1] != MODE_SPLIT);
  // Split high byte uses timer 1 run bit, ungated, timer rate only
  logic run_h0;
  assign run_h0 = timer_control_reg_r[CTRL_TR1_BIT] & tick[0];

  // Prescale counters; in compat mode with double rate a phase bit lets only every other wrap tick
  generate
    for (gi = 0; gi < 2; gi++) begin : g_psc
      always_ff @(posedge clk) begin
        if (reset) begin
          presc_cnt_r[gi] <= PRESCALE_RESET;
          dbl_ph_r[gi] <= 1'b0;
        end else if (presc_cnt_r[gi] == shared_prescale_value_r) begin
          presc_cnt_r[gi] <= PRESCALE_RESET;
          dbl_ph_r[gi] <= ~dbl_ph_r[gi];
        end else begin
          presc_cnt_r[gi] <= presc_cnt_r[gi] + 4'h1;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Counter next-state logic
  logic [7:0] low_nxt [2];
  logic [7:0] high_nxt [2];
  logic ovf [2];
  logic hovf [2];
  logic lovf [2];

  generate
    for (gi = 0; gi < 2; gi++) begin : g_cnt
      always_comb begin
        logic [7:0] msk;
        msk = low_mask(timer_control_b_r[gi*3 +: 3]);
        low_nxt[gi] = cnt_low_r[gi];
        high_nxt[gi] = cnt_high_r[gi];
        ovf[gi] = 1'b0;
        hovf[gi] = 1'b0;
        lovf[gi] = 1'b0;
        if (run[gi]) begin
          unique case (tm[gi])
            MODE_VAR: begin
              // Low byte is the prescaler; only masked bits count
              if ((cnt_low_r[gi] & msk) == msk) begin
                low_nxt[gi] = BYTE_ZERO;
                high_nxt[gi] = cnt_high_r[gi] + 8'h01;
                hovf[gi] = (cnt_high_r[gi] == BYTE_ONES);
                ovf[gi] = hovf[gi];
              end else begin
                low_nxt[gi] = (cnt_low_r[gi] & msk) + 8'h01;
              end
            end
            MODE_R16: begin
              if (pwm_en[gi]) begin
                // Linear prescaler on the low byte
                if (cnt_low_r[gi] == BYTE_ONES) begin
                  low_nxt[gi] = reload_low_r[gi];
                  high_nxt[gi] = cnt_high_r[gi] + 8'h01;
                  hovf[gi] = (cnt_high_r[gi] == BYTE_ONES);
                  ovf[gi] = hovf[gi];
                end else begin
                  low_nxt[gi] = cnt_low_r[gi] + 8'h01;
                end
              end else if ({cnt_high_r[gi], cnt_low_r[gi]} == 16'hFFFF) begin
                low_nxt[gi] = reload_low_r[gi];
                high_nxt[gi] = reload_high_r[gi];
                ovf[gi] = 1'b1;
              end else begin
                {high_nxt[gi], low_nxt[gi]} = {cnt_high_r[gi], cnt_low_r[gi]} + 16'h0001;
              end
            end
            MODE_R8: begin
              if (cnt_low_r[gi] == BYTE_ONES) begin
                low_nxt[gi] = cnt_high_r[gi];
                ovf[gi] = 1'b1;
                lovf[gi] = 1'b1;
              end else begin
                low_nxt[gi] = cnt_low_r[gi] + 8'h01;
              end
            end
            MODE_SPLIT: begin
              // Timer 0 only here: low byte is an 8-bit counter
              low_nxt[gi] = cnt_low_r[gi] + 8'h01;
              ovf[gi] = (cnt_low_r[gi] == BYTE_ONES);
            end
          endcase
        end
        // Split high byte of timer 0 counts on timer 1 run bit
        if (gi == 0 && split0 && run_h0) begin
          high_nxt[gi] = cnt_high_r[gi] + 8'h01;
        end
      end
    end
  endgenerate

  logic h0_split_ovf;
  assign h0_split_ovf = split0 & run_h0 & (cnt_high_r[0] == BYTE_ONES);

  // Timer 1 overflow feeds the baud path even when it cannot raise a flag
  logic t1_flag_set;
  assign t1_flag_set = split0 ? h0_split_ovf : ovf[1];

  ////////////////////////////////////////////////////////////////////////////
  // Register writes and counts; software write beats the count in the same cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      timer_mode_reg_r <= BYTE_ZERO;
      timer_control_b_r <= CTRL_B_RESET;
      clock_control_zero_r <= BYTE_ZERO;
      shared_prescale_value_r <= PRESCALE_RESET;
    end else if (wr) begin
      unique case (addr)
        ADDR_MODE: timer_mode_reg_r <= wdata;
        ADDR_CTRL_B: timer_control_b_r <= wdata;
        ADDR_CLKCTL: clock_control_zero_r <= wdata;
        ADDR_PRESCALE: shared_prescale_value_r <= wdata[3:0];
        default: ;
      endcase
    end
  end

  // Control register: run bits from software, flags set by hardware win
  always_ff @(posedge clk) begin
    if (reset) begin
      timer_control_reg_r <= BYTE_ZERO;
    end else begin
      if (wr && addr == ADDR_CTRL) begin
        timer_control_reg_r <= wdata;
      end
      if (ovf[0]) begin
        timer_control_reg_r[CTRL_TF0_BIT] <= 1'b1;
      end
      if (t1_flag_set) begin
        timer_control_reg_r[CTRL_TF1_BIT] <= 1'b1;
      end
    end
  end

  generate
    for (gi = 0; gi < 2; gi++) begin : g_regs
      always_ff @(posedge clk) begin
        if (reset) begin
          cnt_low_r[gi] <= BYTE_ZERO;
          cnt_high_r[gi] <= BYTE_ZERO;
          reload_low_r[gi] <= RELOAD_RESET;
          reload_high_r[gi] <= RELOAD_RESET;
        end else begin
          cnt_low_r[gi] <= (wr && addr == ADDR_T0_LOW + 4'(2*gi)) ? wdata : low_nxt[gi];
          cnt_high_r[gi] <= (wr && addr == ADDR_T0_HIGH + 4'(2*gi)) ? wdata : high_nxt[gi];
          if (wr && addr == ADDR_T0_RLOW + 4'(2*gi)) begin
            reload_low_r[gi] <= wdata;
          end
          if (wr && addr == ADDR_T0_RHIGH + 4'(2*gi)) begin
            reload_high_r[gi] <= wdata;
          end
        end
      end

      // PWM output: high at overflow with new duty, low on match or zero duty; mode 2 toggles at each low-byte overflow
      always_ff @(posedge clk) begin
        if (reset) begin
          compare_latch_r[gi] <= BYTE_ZERO;
          pwm_out_r[gi] <= 1'b0;
        end else if (!pwm_en[gi]) begin
          pwm_out_r[gi] <= 1'b0;
        end else if (tm[gi] == MODE_R8 && !split0) begin
          if (lovf[gi]) begin
            pwm_out_r[gi] <= ~pwm_out_r[gi];
          end
        end else if (split0) begin
          // Both pins follow timer 0 bytes while timer 0 is split
          if (gi == 1) begin
            // Timer 1 pin carries split high byte of timer 0
            if (h0_split_ovf) begin
              compare_latch_r[gi] <= reload_high_r[0];
              pwm_out_r[gi] <= (reload_high_r[0] != BYTE_ZERO);
            end else if (high_nxt[0] == compare_latch_r[gi]) begin
              pwm_out_r[gi] <= 1'b0;
            end
          end else if (ovf[gi]) begin
            compare_latch_r[gi] <= reload_low_r[0];
            pwm_out_r[gi] <= (reload_low_r[0] != BYTE_ZERO);
          end else if (low_nxt[0] == compare_latch_r[gi]) begin
            pwm_out_r[gi] <= 1'b0;
          end
        end else if (hovf[gi]) begin
          compare_latch_r[gi] <= reload_high_r[gi];
          pwm_out_r[gi] <= (reload_high_r[gi] != BYTE_ZERO);
        end else if (high_nxt[gi] == compare_latch_r[gi]) begin
          // Next count compared so the high time is exactly the duty value
          pwm_out_r[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Pins, flags and baud tick, all registered
  always_ff @(posedge clk) begin
    if (reset) begin
      t0_ext_pin_o <= 1'b0;
      t1_ext_pin_o <= 1'b0;
      t0_ext_pin_oe <= 1'b0;
      t1_ext_pin_oe <= 1'b0;
      t0_overflow_flag <= 1'b0;
      t1_overflow_flag <= 1'b0;
      t1_baud_tick <= 1'b0;
    end else begin
      t0_ext_pin_o <= pwm_out_r[0];
      t1_ext_pin_o <= pwm_out_r[1];
      t0_ext_pin_oe <= pwm_en[0];
      t1_ext_pin_oe <= pwm_en[1] & ~(tm[1] == MODE_SPLIT & ~split0);
      t0_overflow_flag <= timer_control_reg_r[CTRL_TF0_BIT];
      t1_overflow_flag <= timer_control_reg_r[CTRL_TF1_BIT];
      t1_baud_tick <= ovf[1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read port: data valid the cycle after rd; unmapped reads zero
  always_ff @(posedge clk) begin
    if (reset) begin
      rdata <= BYTE_ZERO;
    end else if (rd) begin
      unique case (addr)
        ADDR_MODE: rdata <= timer_mode_reg_r;
        ADDR_CTRL: rdata <= timer_control_reg_r;
        ADDR_CTRL_B: rdata <= timer_control_b_r;
        ADDR_CLKCTL: rdata <= clock_control_zero_r;
        ADDR_T0_LOW: rdata <= cnt_low_r[0];
        ADDR_T0_HIGH: rdata <= cnt_high_r[0];
        ADDR_T1_LOW: rdata <= cnt_low_r[1];
        ADDR_T1_HIGH: rdata <= cnt_high_r[1];
        ADDR_T0_RLOW: rdata <= reload_low_r[0];
        ADDR_T0_RHIGH: rdata <= reload_high_r[0];
        ADDR_T1_RLOW: rdata <= reload_low_r[1];
        ADDR_T1_RHIGH: rdata <= reload_high_r[1];
        ADDR_PRESCALE: rdata <= {4'h0, shared_prescale_value_r};
        default: rdata <= BYTE_ZERO;
      endcase
    end
  end

endmodule

/* dv/timer_chk.sv */
// Port assertions for the dual timer/counter.
// Assumes the register index map and bit positions of timer_pkg.
`timescale 1ns/10ps
module timer_chk
  import timer_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic t0_gate_pin,
  input wire logic t1_gate_pin,
  input wire logic t0_ext_pin_o,
  input wire logic t0_ext_pin_oe,
  input wire logic t1_ext_pin_o,
  input wire logic t1_ext_pin_oe,
  input wire logic t0_overflow_flag,
  input wire logic t1_overflow_flag,
  input wire logic t1_baud_tick
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  logic [7:0] shadow_r [0:11];
  logic [7:0] shadow_rd;
  logic ro_ok, run0, run1, muted1, set0, set1, clr0, clr1;
  //////////////////////////////////////////////////////////////////////////////
  // Mirror of writes to registers 0 to 11; count and flag readback is not checked
  always_ff @(posedge clk) begin
    if (reset) begin
      for (int i = 0; i < 12; i++) begin
        shadow_r[i] <= (i == 2) ? CTRL_B_RESET : 8'h00;
      end
    end else if (wr && addr < ADDR_PRESCALE) begin
      shadow_r[addr] <= wdata;
    end
  end
  assign shadow_rd = (addr < ADDR_PRESCALE) ? shadow_r[addr] : 8'h00;
  assign ro_ok = addr == ADDR_MODE || addr == ADDR_CTRL_B || addr[3:2] == 2'b10;
  assign run0 = shadow_r[1][CTRL_TR0_BIT];
  assign run1 = shadow_r[1][CTRL_TR1_BIT];
  // Timer 1 split mode freezes it; its flag stays quiet unless timer 0 split borrows its run bit
  assign muted1 = shadow_r[0][5:4] == 2'b11 && shadow_r[0][1:0] != 2'b11;
  assign set0 = wr && addr == ADDR_CTRL && wdata[CTRL_TF0_BIT];
  assign set1 = wr && addr == ADDR_CTRL && wdata[CTRL_TF1_BIT];
  assign clr0 = wr && addr == ADDR_CTRL && !wdata[CTRL_TF0_BIT];
  assign clr1 = wr && addr == ADDR_CTRL && !wdata[CTRL_TF1_BIT];
  sequence ctrlb_wr_s;
    wr && addr == ADDR_CTRL_B;
  endsequence
  //////////////////////////////////////////////////////////////////////////////
  // Flags show two cycles after their cause because the outputs lag the register
  chk_readback_value: assert property (rd && ro_ok |=> rdata == $past(shadow_rd))
    else $error("read data differs from stored register");
  chk_unmapped_zero: assert property (rd && addr > ADDR_PRESCALE |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_flag0_sticky: assert property ($fell(t0_overflow_flag) |-> $past(clr0, 2))
    else $error("timer 0 flag dropped without a clearing write");
  chk_flag1_sticky: assert property ($fell(t1_overflow_flag) |-> $past(clr1, 2))
    else $error("timer 1 flag dropped without a clearing write");
  chk_flag0_cause: assert property ($rose(t0_overflow_flag) |-> $past(set0, 2) || $past(run0, 2))
    else $error("timer 0 flag set while stopped");
  chk_flag1_cause: assert property ($rose(t1_overflow_flag) |->
      $past(set1, 2) || $past(run1, 2) && !$past(muted1, 2))
    else $error("timer 1 flag set while stopped or held");
  chk_pwm0_enable: assert property (ctrlb_wr_s |-> ##2 t0_ext_pin_oe == $past(wdata[6], 2))
    else $error("timer 0 pin enable does not follow control B");
  chk_pwm1_enable: assert property (ctrlb_wr_s |-> ##2 t1_ext_pin_oe == $past(wdata[7], 2))
    else $error("timer 1 pin enable does not follow control B");
endmodule
bind dual_timer_counter_pwm timer_chk chk_u (.clk, .reset, .addr, .wdata, .wr, .rd, .rdata,
  .t0_gate_pin, .t1_gate_pin, .t0_ext_pin_o, .t0_ext_pin_oe, .t1_ext_pin_o, .t1_ext_pin_oe,
  .t0_overflow_flag, .t1_overflow_flag, .t1_baud_tick);

/* dv/pin_partner.sv */
// Far side model: drives both gate pins and times the timer 0 output pin.
// Assumes a pull-up on the pin, so a released pin reads high.
`timescale 1ns/10ps
module pin_partner (
  input wire logic clk,
  input wire logic slow,
  input wire logic [1:0] gate_req,
  input wire logic pin_o,
  input wire logic pin_oe,
  output logic t0_gate_pin = 1'b0,
  output logic t1_gate_pin = 1'b0,
  output logic meas_valid = 1'b0,
  output logic [8:0] meas_high,
  output logic [8:0] meas_period
);
  logic lvl;
  logic lvl_q = 1'b1;
  logic [1:0] div_r = 2'b00;
  logic [8:0] run_cnt = 9'h000;
  logic [8:0] high_cnt = 9'h000;
  //////////////////////////////////////////////////////////////////////////////
  // Slow mode answers only every fourth clock, like a lazy external driver
  always_ff @(posedge clk) begin
    div_r <= div_r + 2'b01;
    if (!slow || div_r == 2'b00) begin
      t0_gate_pin <= gate_req[0];
      t1_gate_pin <= gate_req[1];
    end
  end
  // Pin is an output only while enabled; the pull-up wins otherwise
  assign lvl = pin_oe ? pin_o : 1'b1;
  // Each rising edge closes one period and reports its high time
  always_ff @(posedge clk) begin
    lvl_q <= lvl;
    meas_valid <= lvl && !lvl_q;
    if (lvl && !lvl_q) begin
      meas_high <= high_cnt;
      meas_period <= run_cnt;
      run_cnt <= 9'h001;
      high_cnt <= 9'h001;
    end else begin
      run_cnt <= run_cnt + 9'h001;
      high_cnt <= high_cnt + {8'h00, lvl};
    end
  end
endmodule

/* dv/dual_timer_counter_pwm_bench.sv */
// Self-checking bench for the dual timer/counter with PWM outputs.
// Assumes timer_pkg, the checker bind and the pin partner are compiled first.
`timescale 1ns/10ps
module dual_timer_counter_pwm_bench
  import timer_pkg::*;
;
  localparam logic [31:0] SKIP = 32'hFFFF_FFFF;
  logic clk = 1'b0, reset = 1'b1, wr = 1'b0, rd = 1'b0, rd_q = 1'b0, strict = 1'b0, slow = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00, rdata;
  logic [1:0] gate_req = 2'b00;
  logic g0, g1, p0, p0_oe, p1, p1_oe, flag0, flag1, tick, mv;
  logic [8:0] mh, mp;
  logic [31:0] rd_q_exp[$], tick_q[$], pwm_q[$];
  int error_cnt = 0, tests_run = 0, gap = 0;
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #5 clk = ~clk;
  end
  dual_timer_counter_pwm dut_u (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .t0_gate_pin(g0), .t1_gate_pin(g1), .t0_ext_pin_o(p0),
    .t0_ext_pin_oe(p0_oe), .t1_ext_pin_o(p1), .t1_ext_pin_oe(p1_oe), .t0_overflow_flag(flag0),
    .t1_overflow_flag(flag1), .t1_baud_tick(tick));
  pin_partner far_u (.clk(clk), .slow(slow), .gate_req(gate_req), .pin_o(p0), .pin_oe(p0_oe),
    .t0_gate_pin(g0), .t1_gate_pin(g1), .meas_valid(mv), .meas_high(mh), .meas_period(mp));
  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // Oldest note first; while strict, any unexpected result is a fault
  task automatic take(ref logic [31:0] q[$], input logic [31:0] seen);
    logic [31:0] e;
    if (q.size() == 0) begin
      if (strict) check(seen, 32'h0);
    end else begin
      e = q.pop_front();
      if (e !== SKIP) check(seen, e);
    end
  endtask
  always @(posedge clk) begin
    rd_q <= rd;
    gap <= tick ? 1 : gap + 1;
    if (rd_q) take(rd_q_exp, {24'h0, rdata});
    if (tick === 1'b1) take(tick_q, 32'(gap));
    if (mv) take(pwm_q, {7'h00, mh, 7'h00, mp});
  end
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
    rd_q_exp.push_back({24'h0, e});
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
  endtask
  task automatic drain();
    int n;
    n = 0;
    while (rd_q_exp.size() + tick_q.size() + pwm_q.size() > 0 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 3000) check(32'h0, 32'h1);
  endtask
  task automatic print_verdict();
    if (error_cnt == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // A hang costs a mismatch; the whole run needs far less than this
  initial begin
    #1000000;
    error_cnt++;
    print_verdict();
  end
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] v;
    logic [31:0] p;
    int n;
    void'($urandom(32'h1262));
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    // Reset values of control B and the reload bytes, and a refused index
    rd_chk(ADDR_CTRL_B, CTRL_B_RESET);
    for (int a = 8; a < 12; a++) rd_chk(4'(a), RELOAD_RESET);
    rd_chk(4'hE, BYTE_ZERO);
    // Mode 0 width sweep; slow steps keep the wrapped high byte at zero
    wr_reg(ADDR_PRESCALE, 8'h0F);
    wr_reg(ADDR_CLKCTL, 8'h02);
    for (int w = 0; w < 8; w++) begin
      wr_reg(ADDR_CTRL_B, 8'(w));
      wr_reg(ADDR_T0_HIGH, BYTE_ONES);
      wr_reg(ADDR_T0_LOW, 8'((2 << w) - 1));
      wr_reg(ADDR_CTRL, 8'h10);
      n = 0;
      while (flag0 !== 1'b1 && n < 40) begin
        @(posedge clk);
        n++;
      end
      wr_reg(ADDR_CTRL, 8'h20);
      check(32'(n < 40), 32'h1);
      repeat (40) @(posedge clk);
      rd_chk(ADDR_CTRL, 8'h20);
      rd_chk(ADDR_T0_HIGH, BYTE_ZERO);
      wr_reg(ADDR_CTRL, 8'h00);
    end
    // Timer 1 overflow spacing in modes 1 and 2, prescaler on and off
    for (int i = 0; i < 4; i++) begin
      v = 8'hC0 | 8'($urandom % 32);
      n = 1 + $urandom % 3;
      wr_reg(ADDR_MODE, i < 2 ? 8'h10 : 8'h20);
      wr_reg(ADDR_T1_RLOW, v);
      wr_reg(ADDR_T1_RHIGH, BYTE_ONES);
      wr_reg(ADDR_T1_LOW, v);
      wr_reg(ADDR_T1_HIGH, i < 2 ? BYTE_ONES : v);
      wr_reg(ADDR_PRESCALE, 8'(n));
      wr_reg(ADDR_CLKCTL, i == 1 ? 8'h04 : (i == 3 ? 8'h01 : 8'h00));
      p = (32'h100 - v) * ((i % 2 == 1) ? n + 1 : 1);
      tick_q = '{SKIP, p, p};
      wr_reg(ADDR_CTRL, 8'h40);
      drain();
      if (i > 1) rd_chk(ADDR_T1_HIGH, v);
      wr_reg(ADDR_CTRL, 8'h00);
    end
    // Held by its own split mode, then by a low gate pin, then released
    repeat (5) @(posedge clk);
    strict <= 1'b1;
    wr_reg(ADDR_MODE, 8'h30);
    wr_reg(ADDR_CTRL, 8'h40);
    repeat (300) @(posedge clk);
    slow <= 1'b1;
    wr_reg(ADDR_MODE, 8'hA0);
    repeat (300) @(posedge clk);
    strict <= 1'b0;
    tick_q = '{SKIP, p};
    gate_req <= 2'b10;
    drain();
    wr_reg(ADDR_CTRL, 8'h00);
    // Timer 0 PWM: duty change lands only at the next period, zero stays low
    v = 8'h10 + 8'($urandom % 200);
    wr_reg(ADDR_PRESCALE, 8'h00);
    wr_reg(ADDR_CLKCTL, 8'h00);
    wr_reg(ADDR_MODE, 8'h01);
    wr_reg(ADDR_T0_RLOW, BYTE_ONES);
    wr_reg(ADDR_T0_RHIGH, v);
    wr_reg(ADDR_CTRL_B, 8'h40);
    pwm_q = '{SKIP, SKIP, {16'(v), 16'h0100}};
    wr_reg(ADDR_CTRL, 8'h10);
    drain();
    wr_reg(ADDR_T0_RHIGH, v + 8'h20);
    pwm_q = '{{16'(v), 16'h0100}, {16'(v + 8'h20), 16'h0100}};
    drain();
    wr_reg(ADDR_T0_RHIGH, 8'h00);
    repeat (300) @(posedge clk);
    strict <= 1'b1;
    repeat (600) @(posedge clk);
    strict <= 1'b0;
    // Square wave from the 8-bit reload mode
    v = 8'h04 + 8'($urandom % 60);
    wr_reg(ADDR_MODE, 8'h02);
    wr_reg(ADDR_T0_HIGH, 8'(256 - v));
    pwm_q = '{SKIP, SKIP, {16'(v), 16'(2 * v)}};
    drain();
    // Split PWM: low byte on timer 0 pin, then timer 1 pin enable and the high byte flag
    wr_reg(ADDR_T0_RLOW, 8'h40);
    wr_reg(ADDR_CTRL_B, 8'hC0);
    wr_reg(ADDR_MODE, 8'h03);
    pwm_q = '{SKIP, SKIP, {16'h0040, 16'h0100}};
    wr_reg(ADDR_CTRL, 8'h50);
    drain();
    check(32'(p1_oe), 32'h1);
    check(32'(flag1), 32'h1);
    print_verdict();
  end
endmodule
